// >>> core/dword_store_sew.sv
// Function
// - sign-extend word writes back sign extension of bits 31..0
// - source not a sign-extended word gives an unpredictable result
// - register store: opcode 01111, base 10..8, source 7..5, offset 4..0
// - register store address: offset shifted 3, zero-extended, plus base
// - extend prefix supplies sign-extended 16-bit offset added to base
// - every store writes all 64 source bits as one doubleword
// - low 3 address bits nonzero: address error, no memory write
// - stack store: opcode 11111 function 001, offset shifted 3, plus r29
// - extended stack store: sign-extended 16-bit offset plus r29
// - return-address store: 8-bit offset shifted 3 plus r29, stores r31
// - extended return-address store: signed 16-bit offset, stores r31
// - stores report translation, bus, address and reserved exceptions
module dword_store_sew (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic insn_valid,
    input wire logic [31:0] insn,
    input wire logic wide_ops_enabled,
    output logic insn_ready,
    output logic [2:0] reg_a_index,
    output logic [2:0] reg_b_index,
    input wire logic [63:0] reg_a_data,
    input wire logic [63:0] reg_b_data,
    input wire logic [63:0] stack_pointer_reg,
    input wire logic [63:0] return_address_reg,
    output logic wb_valid,
    output logic [2:0] wb_index,
    output logic [63:0] wb_data,
    output logic mem_req,
    output logic [63:0] mem_addr,
    output logic [63:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [2:0] mem_fault,
    output logic exc_valid,
    output logic [2:0] exc_code,
    output logic [63:0] exc_addr,
    output logic done
);
    // ****************************************
    // decode
    // ****************************************
    logic extended;
    logic [15:0] op;
    logic is_reg_store, is_stack_store, is_rasp, is_sew, is_ours;
    logic [63:0] base, addr, store_data;
    logic misaligned;

    assign extended = insn[31:27] == dword_store_pkg::OP_EXTEND;
    assign op = insn[15:0];
    assign is_reg_store =
        op[15:11] == dword_store_pkg::OP_STORE_DWORD;
    assign is_stack_store = op[15:11] == dword_store_pkg::OP_WIDE_GROUP
        && op[10:8] == dword_store_pkg::FN_STACK_DWORD;
    assign is_rasp = op[15:11] == dword_store_pkg::OP_WIDE_GROUP
        && op[10:8] == dword_store_pkg::FN_RA_STACK;
    assign is_sew = !extended
        && op[15:11] == dword_store_pkg::OP_REG_REG
        && op[7:5] == dword_store_pkg::FN_SIGN_EXT_WORD
        && op[4:0] == dword_store_pkg::FN_CONVERT;
    assign is_ours = is_reg_store || is_stack_store || is_rasp || is_sew;
    assign reg_a_index = op[10:8];
    assign reg_b_index = op[7:5];

    always_comb begin
        if (is_reg_store) begin
            base = reg_a_data;
        end else begin
            base = stack_pointer_reg;
        end
        if (is_rasp) begin
            store_data = return_address_reg;
        end else begin
            store_data = reg_b_data;
        end
    end

    dword_addr_gen u_addr (
        .insn(insn),
        .extended(extended),
        .ret_form(is_rasp),
        .base(base),
        .addr(addr),
        .misaligned(misaligned)
    );

    // ****************************************
    // sequencing
    // ****************************************
    dword_store_pkg::store_state_t state_r, state_nxt;
    logic wb_valid_r, wb_valid_nxt;
    logic [2:0] wb_index_r, wb_index_nxt;
    logic [63:0] wb_data_r, wb_data_nxt;
    logic [63:0] mem_addr_r, mem_addr_nxt, mem_wdata_r, mem_wdata_nxt;
    logic exc_valid_r, exc_valid_nxt;
    logic [2:0] exc_code_r, exc_code_nxt;
    logic [63:0] exc_addr_r, exc_addr_nxt;

    assign insn_ready = state_r == dword_store_pkg::ST_IDLE;

    always_comb begin
        state_nxt = state_r;
        wb_valid_nxt = 1'b0;
        wb_index_nxt = wb_index_r;
        wb_data_nxt = wb_data_r;
        mem_addr_nxt = mem_addr_r;
        mem_wdata_nxt = mem_wdata_r;
        exc_valid_nxt = 1'b0;
        exc_code_nxt = exc_code_r;
        exc_addr_nxt = exc_addr_r;
        case (state_r)
            dword_store_pkg::ST_IDLE: begin
                if (insn_valid && is_ours) begin
                    if (!wide_ops_enabled) begin
                        exc_valid_nxt = 1'b1;
                        exc_code_nxt = dword_store_pkg::EXC_RESERVED;
                        exc_addr_nxt = 64'h0;
                        state_nxt = dword_store_pkg::ST_DONE;
                    end else if (is_sew) begin
                        // no word check: a bad source just yields its extension
                        wb_valid_nxt = 1'b1;
                        wb_index_nxt = reg_a_index;
                        wb_data_nxt = {{32{reg_a_data[31]}},
                            reg_a_data[31:0]};
                        state_nxt = dword_store_pkg::ST_DONE;
                    end else if (misaligned) begin
                        exc_valid_nxt = 1'b1;
                        exc_code_nxt = dword_store_pkg::EXC_ADDR;
                        exc_addr_nxt = addr;
                        state_nxt = dword_store_pkg::ST_DONE;
                    end else begin
                        mem_addr_nxt = addr;
                        mem_wdata_nxt = store_data;
                        state_nxt = dword_store_pkg::ST_STORE;
                    end
                end
            end
            dword_store_pkg::ST_STORE: begin
                if (mem_ack) begin
                    if (mem_fault != dword_store_pkg::EXC_NONE) begin
                        exc_valid_nxt = 1'b1;
                        exc_code_nxt = mem_fault;
                        exc_addr_nxt = mem_addr_r;
                    end
                    state_nxt = dword_store_pkg::ST_DONE;
                end
            end
            dword_store_pkg::ST_DONE: begin
                state_nxt = dword_store_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = dword_store_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= dword_store_pkg::ST_IDLE;
            wb_valid_r <= 1'b0;
            wb_index_r <= 3'h0;
            wb_data_r <= 64'h0;
            mem_addr_r <= 64'h0;
            mem_wdata_r <= 64'h0;
            exc_valid_r <= 1'b0;
            exc_code_r <= 3'h0;
            exc_addr_r <= 64'h0;
        end else begin
            state_r <= state_nxt;
            wb_valid_r <= wb_valid_nxt;
            wb_index_r <= wb_index_nxt;
            wb_data_r <= wb_data_nxt;
            mem_addr_r <= mem_addr_nxt;
            mem_wdata_r <= mem_wdata_nxt;
            exc_valid_r <= exc_valid_nxt;
            exc_code_r <= exc_code_nxt;
            exc_addr_r <= exc_addr_nxt;
        end
    end

    assign mem_req = state_r == dword_store_pkg::ST_STORE;
    assign mem_addr = mem_addr_r;
    assign mem_wdata = mem_wdata_r;
    assign wb_valid = wb_valid_r;
    assign wb_index = wb_index_r;
    assign wb_data = wb_data_r;
    assign exc_valid = exc_valid_r;
    assign exc_code = exc_code_r;
    assign exc_addr = exc_addr_r;
    assign done = state_r == dword_store_pkg::ST_DONE;

    // ****************************************
    // checks
    // ****************************************
    chk_sew_result: assert property (
        @(posedge ref_clk) disable iff (rst)
        wb_valid |-> wb_data[63:32] == {32{wb_data[31]}})
        else $error("sign-extend result not extended");
    chk_store_aligned: assert property (
        @(posedge ref_clk) disable iff (rst)
        mem_req |-> mem_addr[2:0] == 3'h0)
        else $error("misaligned doubleword store issued");
    chk_misalign_exc: assert property (
        @(posedge ref_clk) disable iff (rst)
        insn_ready && insn_valid && wide_ops_enabled && !is_sew
        && is_ours && misaligned |=> exc_valid
        && exc_code == dword_store_pkg::EXC_ADDR && !mem_req)
        else $error("misaligned store missed address error");
    chk_reserved_exc: assert property (
        @(posedge ref_clk) disable iff (rst)
        insn_ready && insn_valid && is_ours && !wide_ops_enabled
        |=> exc_valid && exc_code == dword_store_pkg::EXC_RESERVED
        && !mem_req && !wb_valid)
        else $error("disabled wide op not refused");
    chk_reg_store_addr: assert property (
        @(posedge ref_clk) disable iff (rst)
        insn_ready && insn_valid && wide_ops_enabled && is_reg_store
        && !extended && !misaligned
        |=> mem_req && mem_addr == $past(reg_a_data)
        + {56'h0, $past(insn[4:0]), 3'h0})
        else $error("register store address wrong");
    chk_rasp_data: assert property (
        @(posedge ref_clk) disable iff (rst)
        insn_ready && insn_valid && wide_ops_enabled && is_rasp
        && !misaligned |=> mem_req
        && mem_wdata == $past(return_address_reg))
        else $error("return address store data wrong");
    chk_fault_report: assert property (
        @(posedge ref_clk) disable iff (rst)
        mem_req && mem_ack && mem_fault != 3'h0
        |=> exc_valid && exc_code == $past(mem_fault) ##1 !exc_valid)
        else $error("store fault not reported");
    chk_store_done: assert property (
        @(posedge ref_clk) disable iff (rst)
        mem_req && mem_ack |=> done ##1 insn_ready)
        else $error("store did not complete");
endmodule // dword_store_sew

// >>> inc/dword_store_pkg.sv
package dword_store_pkg;
    // ****************************************
    // instruction field layout
    // ****************************************
    localparam logic [4:0] OP_STORE_DWORD = 5'h0F;
    localparam logic [4:0] OP_WIDE_GROUP = 5'h1F;
    localparam logic [4:0] OP_REG_REG = 5'h1D;
    localparam logic [4:0] OP_EXTEND = 5'h1E;
    localparam logic [2:0] FN_STACK_DWORD = 3'h1;
    localparam logic [2:0] FN_RA_STACK = 3'h2;
    localparam logic [2:0] FN_SIGN_EXT_WORD = 3'h6;
    localparam logic [4:0] FN_CONVERT = 5'h11;
    localparam int OP_HI = 15;
    localparam int OP_LO = 11;
    localparam int ALIGN_BITS = 3;
    localparam logic [4:0] REG_STACK = 5'h1D;
    localparam logic [4:0] REG_RETURN = 5'h1F;
    // ****************************************
    // exception codes
    // ****************************************
    localparam logic [2:0] EXC_NONE = 3'h0;
    localparam logic [2:0] EXC_ADDR = 3'h1;
    localparam logic [2:0] EXC_RESERVED = 3'h2;
    localparam logic [2:0] EXC_TLB_REFILL = 3'h3;
    localparam logic [2:0] EXC_TLB_INVALID = 3'h4;
    localparam logic [2:0] EXC_TLB_MODIFIED = 3'h5;
    localparam logic [2:0] EXC_BUS = 3'h6;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_STORE = 2'h1,
        ST_DONE = 2'h3
    } store_state_t;
endpackage

// >>> core/dword_addr_gen.sv
module dword_addr_gen (
    input wire logic [31:0] insn,
    input wire logic extended,
    input wire logic ret_form,
    input wire logic [63:0] base,
    output logic [63:0] addr,
    output logic misaligned
);
    logic [63:0] offset;

    always_comb begin
        if (extended) begin
            // 16-bit offset: 15:11 at 20..16, 10:5 at 26..21, 4:0 at 4..0
            offset = {{48{insn[20]}}, insn[20:16], insn[26:21],
                insn[4:0]};
        end else if (ret_form) begin
            offset = {53'h0, insn[7:0], 3'h0};
        end else begin
            offset = {56'h0, insn[4:0], 3'h0};
        end
    end

    assign addr = base + offset;
    assign misaligned = |addr[dword_store_pkg::ALIGN_BITS-1:0];
endmodule // dword_addr_gen

// >>> verification/mem_partner.sv
module mem_partner (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic [1:0] dly,
    input wire logic [2:0] flt,
    output logic mem_ack,
    output logic [2:0] mem_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_r;
    // fault lines hold junk off the ack cycle, so a late sample shows
    assign mem_fault = mem_ack ? flt : ~flt;
    always_ff @(posedge ref_clk) begin
        if (rst || !mem_req || mem_ack) begin
            cnt_r <= 2'h0;
            mem_ack <= 1'b0;
        end else if (cnt_r == dly) begin
            mem_ack <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule // mem_partner

// >>> verification/dword_store_sew_test.sv
module compact_isa_dword_store_sew_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, insn_valid, wide_ops_enabled, insn_ready;
    logic [31:0] insn, seed, w;
    logic [2:0] ai, bi, wb_index, mem_fault, exc_code, flt_r;
    logic [63:0] rf [8];
    logic [63:0] stack_v, ret_v, wb_data, mem_addr, mem_wdata, exc_addr;
    logic wb_valid, mem_req, mem_ack, exc_valid, done;
    logic [1:0] dly_r;
    logic [15:0] hi, lo;
    int bad_count, checks_done, it, r;
    dword_store_sew dut (.ref_clk(ref_clk), .rst(rst),
        .insn_valid(insn_valid), .insn(insn),
        .wide_ops_enabled(wide_ops_enabled), .insn_ready(insn_ready),
        .reg_a_index(ai), .reg_b_index(bi), .reg_a_data(rf[ai]),
        .reg_b_data(rf[bi]), .stack_pointer_reg(stack_v),
        .return_address_reg(ret_v), .wb_valid(wb_valid),
        .wb_index(wb_index), .wb_data(wb_data), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_fault(mem_fault), .exc_valid(exc_valid),
        .exc_code(exc_code), .exc_addr(exc_addr), .done(done));
    mem_partner mem (.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req),
        .dly(dly_r), .flt(flt_r), .mem_ack(mem_ack),
        .mem_fault(mem_fault));
    // ****************************************
    // checking
    // ****************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one issue, then watch until done; model worked out from fields
    task automatic run(input logic [31:0] i, input logic en,
                       input logic [2:0] f, input logic [1:0] d);
        logic [63:0] off, base, ea, ed, xa, ga, gd, gw, gx;
        logic [2:0] xc, ec, gi;
        logic sw, ws, em, sm, ew, sb, dn, rd;
        @(posedge ref_clk);
        insn_valid <= 1'b1;
        insn <= i;
        wide_ops_enabled <= en;
        flt_r <= f;
        dly_r <= d;
        sw = i[15:11] == 5'h1D;
        ws = i[15:11] == 5'h1F;
        off = {{48{i[20]}}, i[20:16], i[26:21], i[4:0]};
        if (i[31:27] != 5'h1E) off = {56'h0, i[4:0], 3'h0};
        base = (i[15:11] == 5'h0F) ? rf[i[10:8]] : stack_v;
        ed = rf[i[7:5]];
        if (ws && i[10:8] == 3'h2) begin
            ed = ret_v;
            if (i[31:27] != 5'h1E) off = {53'h0, i[7:0], 3'h0};
        end
        ea = base + off;
        if (sw) ed = {{32{rf[i[10:8]][31]}}, rf[i[10:8]][31:0]};
        em = en && !sw && ea[2:0] == 3'h0;
        ew = en && sw;
        xc = !en ? 3'h2 : sw ? 3'h0 : (ea[2:0] != 3'h0) ? 3'h1 : f;
        xa = (xc == 3'h2) ? 64'h0 : ea;
        sm = 1'b0;
        sb = 1'b0;
        ec = 3'h0;
        @(posedge ref_clk);
        insn_valid <= 1'b0;
        dn = 1'b0;
        rd = 1'b1;
        // first look right after the taking edge: pulses stand one cycle
        for (int n = 0; n < 20; n++) begin
            #1;
            if (n == 0) rd = insn_ready;
            if (mem_req === 1'b1 && !sm) begin
                sm = 1'b1;
                ga = mem_addr;
                gd = mem_wdata;
            end
            if (wb_valid === 1'b1) begin
                sb = 1'b1;
                gw = wb_data;
                gi = wb_index;
            end
            if (exc_valid === 1'b1) begin
                ec = exc_code;
                gx = exc_addr;
            end
            if (done === 1'b1) begin
                dn = 1'b1;
                break;
            end
            @(posedge ref_clk);
        end
        chk(64'(dn), 64'h1);
        chk(64'(rd), 64'h0);
        chk(64'(sm), 64'(em));
        chk(64'(sb), 64'(ew));
        chk(64'(ec), 64'(xc));
        if (em) chk(ga, ea);
        if (em) chk(ga, ea);
        if (em) chk(gd, ed);
        if (xc != 3'h0) chk(gx, xa);
        if (ew) chk(gw, ed);
        if (ew) chk(64'(gi), 64'(i[10:8]));
    endtask
    // ****************************************
    // stimulus
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        end_sim();
    end
    initial begin
        seed = 32'hDE8470CE;
        rst = 1'b1;
        insn_valid = 1'b0;
        insn = 32'h0;
        wide_ops_enabled = 1'b1;
        flt_r = 3'h0;
        dly_r = 2'h0;
        stack_v = 64'h0;
        ret_v = 64'h0;
        for (r = 0; r < 8; r++) rf[r] = 64'h0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        for (it = 0; it < 140; it++) begin
            w = $random(seed);
            @(posedge ref_clk);
            // every fourth op leaves the low bits in, to hit misalignment
            for (r = 0; r < 8; r++)
                rf[r] <= {$random(seed), $random(seed) & ((it % 4 == 3)
                    ? 32'hFFFFFFFF : 32'hFFFFFFF8)};
            stack_v <= {$random(seed), $random(seed) & ((it % 4 == 3)
                ? 32'hFFFFFFFF : 32'hFFFFFFF8)};
            ret_v <= {$random(seed), $random(seed)};
            hi = (it % 7 % 2 == 1) ? {5'h1E, w[26:16]} : 16'h0;
            case (it % 7 / 2)
                0: lo = {5'h0F, w[10:0]};
                1: lo = {5'h1F, 3'h1, w[7:0]};
                2: lo = {5'h1F, 3'h2, (it % 7 == 5) ? 3'h0 : w[7:5], w[4:0]};
                default: lo = {5'h1D, w[10:8], 3'h6, 5'h11};
            endcase
            if (it % 7 % 2 == 1 && it % 4 != 3) lo[2:0] = 3'h0;
            run({hi, lo}, it % 11 != 5,
                (it % 5 == 0) ? 3'h0 : 3'(it % 5 + 2), w[29:28]);
        end
        end_sim();
    end
endmodule // compact_isa_dword_store_sew_test
